/* logic/hlc_pkg.sv */
// Package for the host link control register bank: offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus running on the single 100 MHz core clock.
package hlc_pkg;

  // Byte offsets of the registers.
  localparam logic [7:0] OFF_CTRL_SET = 8'h50;
  localparam logic [7:0] OFF_CTRL_CLR = 8'h54;
  localparam logic [7:0] OFF_BUF_BASE = 8'h64;
  localparam logic [7:0] OFF_ID_COUNT = 8'h68;
  localparam logic [7:0] OFF_MASK_SET = 8'h70;
  localparam logic [7:0] OFF_MASK_CLR = 8'h74;

  // Host link control field positions.
  localparam int BIT_DATA_SWAP_DISABLE = 30;
  localparam int BIT_PHY_PERMIT = 23;
  localparam int BIT_ENHANCE_USE = 22;
  localparam int BIT_LINK_POWER = 19;
  localparam int BIT_POSTED_WRITE = 18;
  localparam int BIT_LINK_ACTIVE = 17;
  localparam int BIT_RESET_REQ = 16;

  // Bits of the control word that software may set; the permit bit is clear only.
  localparam logic [31:0] CTRL_SET_MASK = 32'h404f_0000;
  localparam logic [31:0] CTRL_CLR_MASK = 32'h40ce_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Buffer base keeps bits 31:11 only (2 Kbyte alignment).
  localparam logic [31:0] BUF_BASE_MASK = 32'hffff_f800;
  localparam logic [31:0] BUF_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // Count register field positions.
  localparam int BIT_ID_ERROR = 31;
  localparam int GEN_LSB = 16;
  localparam int SIZE_LSB = 2;
  localparam int GEN_W = 8;
  localparam int SIZE_W = 9;

  // Soft reset duration in cycles: long enough to flush internal state.
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;

  // AHB transfer types.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

/* logic/hlc_regs.sv */
// Host link control and node identification register bank with an AHB-Lite slave port.
// Assumes the link core reports bus resets and identification reception events as
// one-cycle pulses synchronous to clk_i, and that the EEPROM loader pulses its strobe once.
//
// Notes on behaviour
// [RL1] Bit 30 selects data byte swapping.
// [RL2] Permit bit: clear-only, loadable from EEPROM.
// [RL3] Software leaves enhancements alone when permit zero.
// [RL4] Use bit set only with permit and link.
// [RL5] Link power bit gates all PHY communication.
// [RL6] Posted write bit enables posted writes.
// [RL7] Change posted write only while link inactive.
// [RL8] Hard and soft reset clear link active.
// [RL9] Link inactive stops all bus traffic.
// [RL10] Software sets link active, then forces reset.
// [RL11] Soft reset clears state, FIFOs, registers.
// [RL12] Soft reset bit reads one until done.
// [RL13] Buffer base keeps bits 31:11, rest zero.
// [RL14] Error flag follows latest reception outcome.
// [RL15] Generation increments per bus reset, wraps.
// [RL16] Size counts quadlets, clears at reception start.
// [RL17] Upper mask set/clear pair, both read mask.
// [RL18] Control register is set/clear at 50h/54h.
// [RL19] Mask bit n enables channel n+32.
// [RL20] Ones set or clear; zeros leave alone.
// [RL21] Count register is hardware updated only.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

module hlc_regs (
  input wire logic clk_i,
  input wire logic resetn_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // EEPROM load of the permit bit.
  input wire logic eeprom_load_i,
  input wire logic eeprom_permit_i,
  // Link core events.
  input wire logic bus_reset_i,
  input wire logic id_rx_start_i,
  input wire logic id_quadlet_i,
  input wire logic id_rx_done_i,
  input wire logic id_rx_error_i,
  // Controls toward the link core.
  output logic data_swap_disable_o,
  output logic enhancement_use_enable_o,
  output logic link_power_status_o,
  output logic posted_write_on_o,
  output logic link_active_o,
  output logic traffic_enable_o,
  output logic core_reset_o,
  output logic [31:0] node_id_buffer_base_o,
  output logic [63:32] upper_channel_receive_mask_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers shared by the register decode and the set/clear pairs.

  // Write strobe for one offset; only a captured write data phase may hit.
  function automatic logic phase_hit(input logic pend, input logic [7:0] a,
    input logic [7:0] off);
    return pend && (a == off);
  endfunction

  // One set/clear step: a one sets or clears its bit, a zero leaves it alone.
  // Clear is applied first, so a bit named in both words ends up set.
  function automatic logic [31:0] pair_update(input logic [31:0] cur,
    input logic [31:0] set_w, input logic [31:0] clr_w);
    return (cur & ~clr_w) | set_w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: capture the address phase, act in the data phase.

  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [3:0] rst_cnt_q;
  logic [31:0] ctrl_q;
  logic [31:0] base_q;
  logic [31:0] mask_q;
  logic id_error_q;
  logic [7:0] gen_q;
  logic [8:0] size_q;
  logic soft_rst;

  // Word access only; narrower sizes are still taken as whole words.
  wire logic take = hsel_i && hready_i && (htrans_i == hlc_pkg::HTRANS_NONSEQ);
  wire logic wr_ctrl_set = phase_hit(wr_pend_q, addr_q, hlc_pkg::OFF_CTRL_SET);
  wire logic wr_ctrl_clr = phase_hit(wr_pend_q, addr_q, hlc_pkg::OFF_CTRL_CLR);
  wire logic wr_base = phase_hit(wr_pend_q, addr_q, hlc_pkg::OFF_BUF_BASE);
  wire logic wr_mask_set = phase_hit(wr_pend_q, addr_q, hlc_pkg::OFF_MASK_SET);
  wire logic wr_mask_clr = phase_hit(wr_pend_q, addr_q, hlc_pkg::OFF_MASK_CLR);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take && hwrite_i;
      if (take)
        addr_q <= {haddr_i[7:2], 2'h0};
    end
  end

  // Always ready, always OKAY; the slave never inserts wait states.
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // Reads return combinationally from the captured address; unmapped reads give zero.
  wire logic [31:0] count_word = {id_error_q, 7'h00, gen_q, 5'h00, size_q, 2'h0};
  always_comb
  begin
    unique case (addr_q)
      hlc_pkg::OFF_CTRL_SET, hlc_pkg::OFF_CTRL_CLR: hrdata_o = ctrl_q; // RL18
      hlc_pkg::OFF_BUF_BASE: hrdata_o = base_q;
      hlc_pkg::OFF_ID_COUNT: hrdata_o = count_word;
      hlc_pkg::OFF_MASK_SET, hlc_pkg::OFF_MASK_CLR: hrdata_o = mask_q; // RL17
      default: hrdata_o = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer: the request bit stays up while the counter runs.

  assign soft_rst = ctrl_q[hlc_pkg::BIT_RESET_REQ];
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_cnt_q <= 4'h0;
    else if (!soft_rst)
      rst_cnt_q <= 4'h0;
    else
      rst_cnt_q <= rst_cnt_q + 4'h1; // RL12
  end
  wire logic rst_done = soft_rst && (rst_cnt_q == hlc_pkg::SOFT_RESET_CYCLES - 4'h1);

  ////////////////////////////////////////////////////////////////////////////////
  // Control word: set/clear pair with a clear-only permit bit.

  // Enhancement use may only be set while permit and link active are both one.
  wire logic use_ok = ctrl_q[hlc_pkg::BIT_PHY_PERMIT] && ctrl_q[hlc_pkg::BIT_LINK_ACTIVE];
  wire logic [31:0] set_bits = (wr_ctrl_set ? (hwdata_i & hlc_pkg::CTRL_SET_MASK) : 32'h0)
    & ~(use_ok ? 32'h0 : (32'h1 << hlc_pkg::BIT_ENHANCE_USE)); // RL4
  wire logic [31:0] clr_bits = wr_ctrl_clr ? (hwdata_i & hlc_pkg::CTRL_CLR_MASK) : 32'h0;
  wire logic [31:0] ctrl_upd = pair_update(ctrl_q, set_bits, clr_bits); // RL20

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctrl_q <= hlc_pkg::CTRL_RESET; // RL8
    else if (rst_done)
      ctrl_q <= hlc_pkg::CTRL_RESET; // RL11 RL8
    else if (soft_rst)
      ctrl_q <= ctrl_q;
    else if (eeprom_load_i)
      ctrl_q <= {ctrl_upd[31:24], eeprom_permit_i, ctrl_upd[22:0]}; // RL2
    else
      ctrl_q <= ctrl_upd; // RL2 RL18
  end

  assign data_swap_disable_o = ctrl_q[hlc_pkg::BIT_DATA_SWAP_DISABLE]; // RL1
  assign enhancement_use_enable_o = ctrl_q[hlc_pkg::BIT_ENHANCE_USE];
  assign link_power_status_o = ctrl_q[hlc_pkg::BIT_LINK_POWER]; // RL5
  assign posted_write_on_o = ctrl_q[hlc_pkg::BIT_POSTED_WRITE]; // RL6
  assign link_active_o = ctrl_q[hlc_pkg::BIT_LINK_ACTIVE];
  // Traffic needs both the link active and the PHY link powered.
  assign traffic_enable_o = link_active_o && link_power_status_o && !soft_rst; // RL9 RL5
  assign core_reset_o = soft_rst; // RL11

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer base and upper channel mask.

  // Both words of the mask pair go through one update; zeros written leave bits alone.
  wire logic [31:0] mask_set_bits = wr_mask_set ? hwdata_i : 32'h0000_0000;
  wire logic [31:0] mask_clr_bits = wr_mask_clr ? hwdata_i : 32'h0000_0000;
  wire logic [31:0] mask_upd = pair_update(mask_q, mask_set_bits, mask_clr_bits);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      base_q <= hlc_pkg::BUF_BASE_RESET;
      mask_q <= hlc_pkg::MASK_RESET;
    end
    else if (rst_done)
    begin
      base_q <= hlc_pkg::BUF_BASE_RESET;
      mask_q <= hlc_pkg::MASK_RESET;
    end
    else
    begin
      if (wr_base)
        base_q <= hwdata_i & hlc_pkg::BUF_BASE_MASK; // RL13
      mask_q <= mask_upd; // RL20 RL17
    end
  end
  assign node_id_buffer_base_o = base_q;
  assign upper_channel_receive_mask_o = mask_q; // RL19

  ////////////////////////////////////////////////////////////////////////////////
  // Identification count: hardware only, bus writes ignored.

  // Events are dropped while the link is inactive or resetting.
  wire logic live = traffic_enable_o;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      id_error_q <= 1'b0;
      gen_q <= 8'h00;
      size_q <= 9'h000;
    end
    else if (rst_done)
    begin
      id_error_q <= 1'b0;
      gen_q <= 8'h00;
      size_q <= 9'h000;
    end
    else if (live)
    begin
      if (bus_reset_i)
        gen_q <= gen_q + 8'h01; // RL15 RL21
      if (id_rx_start_i)
        size_q <= 9'h000; // RL16
      else if (id_quadlet_i)
        size_q <= size_q + 9'h001; // RL16
      if (id_rx_done_i)
        id_error_q <= id_rx_error_i; // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // A soft reset request is the first cycle in which the request bit stands.
  sequence s_reset_req;
    soft_rst && !$past(soft_rst);
  endsequence

  // The request bit then holds for the whole sequencer run.
  sequence s_reset_hold;
    soft_rst [*8];
  endsequence

  // Bus answer and read path.
  a_bus_answer: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL18
    hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  a_mask_read: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL17
    (addr_q == hlc_pkg::OFF_MASK_SET || addr_q == hlc_pkg::OFF_MASK_CLR)
    |-> hrdata_o == upper_channel_receive_mask_o)
    else $error("mask read does not show the mask");

  // Soft reset run.
  a_soft_reset_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL12
    s_reset_req |-> s_reset_hold ##1 !soft_rst)
    else $error("soft reset did not last eight cycles");
  a_reset_outputs: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL11 RL9
    s_reset_req |-> core_reset_o && !traffic_enable_o)
    else $error("core not held in reset");
  a_reset_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL11
    soft_rst && !rst_done |=> $stable(ctrl_q))
    else $error("control word changed during soft reset");
  a_link_cleared: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL8
    rst_done |=> !link_active_o && ctrl_q == hlc_pkg::CTRL_RESET)
    else $error("soft reset left control bits set");

  // Control word.
  a_permit_noset: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL2
    !ctrl_q[hlc_pkg::BIT_PHY_PERMIT] && !eeprom_load_i |=> !ctrl_q[hlc_pkg::BIT_PHY_PERMIT])
    else $error("permit bit set by software");
  a_eeprom_load: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL2
    eeprom_load_i && !soft_rst |=> ctrl_q[hlc_pkg::BIT_PHY_PERMIT] == $past(eeprom_permit_i))
    else $error("permit bit not loaded");
  a_use_guard: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL4
    !enhancement_use_enable_o && !use_ok |=> !enhancement_use_enable_o)
    else $error("enhancement use set without permit");
  a_swap_follow: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL1
    wr_ctrl_set && hwdata_i[hlc_pkg::BIT_DATA_SWAP_DISABLE] && !soft_rst
    |=> data_swap_disable_o)
    else $error("swap control not set");
  a_posted_follow: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL6
    wr_ctrl_set && hwdata_i[hlc_pkg::BIT_POSTED_WRITE] && !soft_rst |=> posted_write_on_o)
    else $error("posted write control not set");
  a_power_follow: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL5
    wr_ctrl_clr && hwdata_i[hlc_pkg::BIT_LINK_POWER] && !soft_rst |=> !link_power_status_o)
    else $error("link power not cleared");
  a_link_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL20
    wr_ctrl_clr && hwdata_i[hlc_pkg::BIT_LINK_ACTIVE] && !soft_rst |=> !link_active_o)
    else $error("link active not cleared");

  // Traffic gating.
  a_traffic_gate: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL9
    !link_active_o |-> !traffic_enable_o)
    else $error("traffic while link inactive");
  a_power_gate: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL5
    !link_power_status_o |-> !traffic_enable_o)
    else $error("traffic while link unpowered");
  a_idle_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL9
    !live && !rst_done |=> $stable(gen_q) && $stable(size_q) && $stable(id_error_q))
    else $error("count changed while link idle");

  // Buffer base and channel mask.
  a_base_low_zero: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL13
    base_q[10:0] == 11'h000)
    else $error("buffer base low bits not zero");
  a_base_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL13
    wr_base && !rst_done |=> base_q == ($past(hwdata_i) & hlc_pkg::BUF_BASE_MASK))
    else $error("buffer base write lost");
  a_mask_set: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL17 RL20
    wr_mask_set && !rst_done |=> (mask_q & $past(hwdata_i)) == $past(hwdata_i))
    else $error("mask set failed");
  a_mask_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL17 RL20
    wr_mask_clr && !rst_done |=> (mask_q & $past(hwdata_i)) == 32'h0000_0000)
    else $error("mask clear failed");

  // Identification count.
  a_gen_wrap: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL15
    live && bus_reset_i && !rst_done |=> gen_q == $past(gen_q) + 8'h01)
    else $error("generation did not step");
  a_size_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL16
    live && id_rx_start_i |=> size_q == 9'h000)
    else $error("size not cleared at start");
  a_size_step: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL16
    live && id_quadlet_i && !id_rx_start_i |=> size_q == $past(size_q) + 9'h001)
    else $error("size did not step");
  a_size_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL16
    live && !id_rx_start_i && !id_quadlet_i |=> $stable(size_q))
    else $error("size moved without a quadlet");
  a_err_follow: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL14
    live && id_rx_done_i && !rst_done |=> id_error_q == $past(id_rx_error_i))
    else $error("error flag not updated");
  a_err_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL14
    live && id_rx_done_i && !id_rx_error_i |=> !id_error_q)
    else $error("error flag not cleared");
  a_count_ro: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL21
    phase_hit(wr_pend_q, addr_q, hlc_pkg::OFF_ID_COUNT) && !bus_reset_i && !id_rx_start_i
    && !id_quadlet_i && !id_rx_done_i && !rst_done |=> $stable(count_word))
    else $error("count register changed by a bus write");

endmodule

/* bench/hlc_link_model.sv */
// Link core stand-in: emits bus reset, identification reception and EEPROM load pulses.
// Assumes one caller process drives its tasks, each starting just after a clk_i edge.
`timescale 1ns/1ps

module hlc_link_model (
  input wire logic clk_i,
  output logic bus_reset_o = 1'b0,
  output logic rx_start_o = 1'b0,
  output logic quadlet_o = 1'b0,
  output logic rx_done_o = 1'b0,
  output logic rx_error_o = 1'b0,
  output logic load_o = 1'b0,
  output logic permit_o = 1'b0
);
  // One pulse per bus reset; gating by link state is left to the register bank.
  task automatic bus_reset();
    begin
      @(posedge clk_i) bus_reset_o <= 1'b1;
      @(posedge clk_i) bus_reset_o <= 1'b0;
    end
  endtask

  // Header plus data quadlets, then the outcome; levels flip once released so none is trusted.
  task automatic receive(input int n, input logic err);
    begin
      @(posedge clk_i) rx_start_o <= 1'b1;
      @(posedge clk_i) rx_start_o <= 1'b0;
      quadlet_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      quadlet_o <= 1'b0;
      rx_done_o <= 1'b1;
      rx_error_o <= err;
      @(posedge clk_i) rx_done_o <= 1'b0;
      rx_error_o <= ~err;
    end
  endtask

  // EEPROM loader strobe carrying the permit level.
  task automatic eeprom(input logic p);
    begin
      @(posedge clk_i) load_o <= 1'b1;
      permit_o <= p;
      @(posedge clk_i) load_o <= 1'b0;
      permit_o <= ~p;
    end
  endtask
endmodule

/* bench/tb.sv */
// Self-checking bench for the host link control register bank.
// Assumes an AHB-Lite master here and the link model on the event side.
`timescale 1ns/1ps

module tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, hready_i, dsw, enh, link_power_status, pw, la, te, crst;
  wire br, st, qd, dn, er, ld, pm;
  wire [31:0] base;
  wire [63:32] mask;
  int fails = 0;
  int n_compared = 0;
  integer seed = 82;
  logic [31:0] ctrl, rd, r1, r2;
  logic [7:0] offs [7] = '{8'h50, 8'h54, 8'h64, 8'h68, 8'h70, 8'h74, 8'h60};

  assign hready_i = hreadyout_o;
  always #5 clk_i = ~clk_i;

  hlc_regs u_dut (.clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .eeprom_load_i(ld),
    .eeprom_permit_i(pm), .bus_reset_i(br), .id_rx_start_i(st), .id_quadlet_i(qd),
    .id_rx_done_i(dn), .id_rx_error_i(er), .data_swap_disable_o(dsw),
    .enhancement_use_enable_o(enh), .link_power_status_o(link_power_status), .posted_write_on_o(pw),
    .link_active_o(la), .traffic_enable_o(te), .core_reset_o(crst),
    .node_id_buffer_base_o(base), .upper_channel_receive_mask_o(mask));
  hlc_link_model u_link (.clk_i, .bus_reset_o(br), .rx_start_o(st), .quadlet_o(qd),
    .rx_done_o(dn), .rx_error_o(er), .load_o(ld), .permit_o(pm));

  ////////////////////////////////////////////////////////////////////////////
  // Expected control outputs packed from a control word.
  function automatic logic [31:0] ctl_out(input logic [31:0] c);
    return {27'h0, c[30], c[22], c[19], c[18], c[17]};
  endfunction

  // Expected count register image.
  function automatic logic [31:0] cnt(input logic e, input logic [7:0] g, input logic [8:0] s);
    return {e, 7'h0, g, 5'h0, s, 2'h0};
  endfunction

  task automatic print_verdict();
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        fails++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // One single transfer; every wait is bounded since the slave's latency is not assumed.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      htrans_i <= hlc_pkg::HTRANS_NONSEQ;
      do @(posedge clk_i) n++; while (hready_i !== 1'b1 && n < 50);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i) n++; while (hready_i !== 1'b1 && n < 50);
      q = hrdata_o;
      if (n >= 50)
      begin
        fails++;
        print_verdict();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then one block per feature, each with its own report line.
  initial
  begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (offs[i])
    begin
      bus(0, offs[i], 32'h0, rd);
      chk(rd, 32'h0);
    end
    chk({30'h0, hreadyout_o, hresp_o}, 32'h0000_0002);
    $display("test reset values done");
    ctrl = 32'h0;
    repeat (6)
    begin
      r1 = $random(seed) & ~32'h0003_0000;
      r2 = $random(seed) & ~32'h0003_0000;
      bus(1, 8'h50, r1, rd);
      ctrl = ctrl | (r1 & hlc_pkg::CTRL_SET_MASK & ~32'h0040_0000);
      bus(0, 8'h54, 32'h0, rd);
      chk(rd, ctrl);
      chk(ctl_out(ctrl), {27'h0, dsw, enh, link_power_status, pw, la});
      bus(1, 8'h54, r2, rd);
      ctrl = ctrl & ~(r2 & hlc_pkg::CTRL_CLR_MASK);
      bus(0, 8'h50, 32'h0, rd);
      chk(rd, ctrl);
    end
    bus(1, 8'h54, 32'hffff_ffff, rd);
    u_link.eeprom(1'b1);
    bus(1, 8'h50, 32'h0040_0000, rd);
    bus(0, 8'h50, 32'h0, rd);
    chk(rd, 32'h0080_0000);
    bus(1, 8'h50, 32'h0002_0000, rd);
    bus(1, 8'h50, 32'h0040_0000, rd);
    bus(1, 8'h54, 32'h0080_0000, rd);
    bus(1, 8'h50, 32'h0080_0000, rd);
    bus(0, 8'h54, 32'h0, rd);
    chk(rd, 32'h0042_0000);
    chk({31'h0, enh}, 32'h1);
    $display("test control pair done");
    r1 = $random(seed);
    r2 = $random(seed);
    bus(1, 8'h64, r1, rd);
    bus(0, 8'h64, 32'h0, rd);
    chk(rd, r1 & hlc_pkg::BUF_BASE_MASK);
    chk(base, r1 & hlc_pkg::BUF_BASE_MASK);
    bus(1, 8'h70, r1, rd);
    bus(1, 8'h74, r2, rd);
    bus(0, 8'h70, 32'h0, rd);
    chk(rd, r1 & ~r2);
    bus(0, 8'h74, 32'h0, rd);
    chk(rd, r1 & ~r2);
    chk(mask, r1 & ~r2);
    $display("test base and mask done");
    bus(1, 8'h50, 32'h000a_0000, rd);
    repeat (259) u_link.bus_reset();
    u_link.receive(5, 1'b1);
    bus(0, 8'h68, 32'h0, rd);
    chk(rd, cnt(1'b1, 8'h03, 9'h005));
    u_link.receive(2, 1'b0);
    bus(1, 8'h68, 32'hffff_ffff, rd);
    bus(0, 8'h68, 32'h0, rd);
    chk(rd, cnt(1'b0, 8'h03, 9'h002));
    bus(1, 8'h54, 32'h0002_0000, rd);
    u_link.bus_reset();
    bus(0, 8'h68, 32'h0, rd);
    chk(rd, cnt(1'b0, 8'h03, 9'h002));
    chk({31'h0, te}, 32'h0);
    $display("test count register done");
    bus(1, 8'h50, 32'h0002_0000, rd);
    bus(1, 8'h50, 32'h0001_0000, rd);
    bus(0, 8'h50, 32'h0, rd);
    chk(rd & 32'h0001_0000, 32'h0001_0000);
    chk({30'h0, crst, te}, 32'h2);
    for (int k = 0; k < 20 && rd[16] !== 1'b0; k++) bus(0, 8'h50, 32'h0, rd);
    chk(rd, 32'h0);
    foreach (offs[i])
    begin
      bus(0, offs[i], 32'h0, rd);
      chk(rd, 32'h0);
    end
    chk({31'h0, la}, 32'h0);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
